// [verif/byte_io_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
module byte_io_ctrl_test;
  import byte_io_pkg::*;
  localparam int    STEP = 4;
  localparam byte_t IN_B = 8'hA5;
  localparam byte_t T_B  = 8'h5A;
  logic    clk_sys = 1'b0;
  logic    rst     = 1'b1;
  cmd_t    cmdIn   = '0;
  logic    cmdValid = 1'b0;
  byte_t   tRegIn = T_B, fileIn = 8'hC3, inBusIn, senseSwIn = 8'h81;
  byte_t   statusIn = 8'h42, consoleSwIn = 8'h7E;
  logic    cmdTaken, spaceOut, inputFlag;
  mode_t   ioMode;
  strobe_t ioStrobe;
  result_t result;
  int      n_mismatch = 0, comparisons = 0, cycles = 0;
  mode_t   prev;
  // ----
  // Design and peripheral
  // ----
  byte_io_ctrl #(.STEP_CYCLES(STEP)) DUT (.clk_sys(clk_sys), .rst(rst), .cmdIn(cmdIn),
    .cmdValid(cmdValid), .tRegIn(tRegIn), .fileIn(fileIn), .inBusIn(inBusIn),
    .senseSwIn(senseSwIn), .statusIn(statusIn), .consoleSwIn(consoleSwIn),
    .cmdTaken(cmdTaken), .ioMode(ioMode), .ioStrobe(ioStrobe), .spaceOut(spaceOut),
    .inputFlag(inputFlag), .result(result));
  periph_model #(.IN_BYTE(IN_B)) PERIPH (.clk_sys(clk_sys), .ioStrobe(ioStrobe),
    .inBus(inBusIn));
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ----
  // Helpers
  // ----
  task automatic chk(input string name, input byte_t exp, input byte_t got);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic docmd(input logic [3:0] opc, input logic [3:0] c, input mode_t m,
                       input logic v, input byte_t d);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    cmdIn = '{opcode: opc, file: ~c, cfield: c, inhibit: c[0], dest: 3'h2};
    cmdValid = 1'b1;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (cmdTaken !== 1'b1 && n < 9);
    cmdValid = 1'b0;
    chk("cmdTaken", 8'h01, {7'h00, cmdTaken});
    chk("valid", {7'h00, v}, {7'h00, result.valid});
    if (v) chk("data", d, result.data);
    chk("ioMode", {5'h00, m}, {5'h00, ioMode});
    chk("ioStrobe", 8'h01 << m, ioStrobe);
    chk("spaceOut", {7'h00, m == 3'h3}, {7'h00, spaceOut});
    chk("inputFlag", {7'h00, m[2]}, {7'h00, inputFlag});
    if (opc == 4'h7) begin
      chk("resFile", {4'h0, ~c}, {4'h0, result.file});
      chk("resDest", 8'h02, {5'h00, result.dest});
      chk("resInhibit", {7'h00, c[0]}, {7'h00, result.inhibit});
    end
  endtask
  task automatic t_reset();
    @(posedge clk_sys);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("ioMode", 8'h00, {5'h00, ioMode});
    chk("ioStrobe", 8'h01, ioStrobe);
    chk("result", 8'h00, {result.valid, result.data[6:0]});
    $display("reset test done");
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_internal();
    docmd(4'h7, 4'h0, 3'h0, 1'b0, 8'h00);
    docmd(4'h7, 4'h1, 3'h0, 1'b1, 8'h81);
    docmd(4'h7, 4'h2, 3'h0, 1'b1, 8'h0C);
    docmd(4'h7, 4'h4, 3'h0, 1'b1, 8'h42);
    docmd(4'h7, 4'h7, 3'h0, 1'b1, 8'h7E);
    docmd(4'h7, 4'h3, 3'h0, 1'b0, 8'h00);
    $display("internal functions test done");
  endtask
  task automatic t_modes();
    prev = 3'h0;
    for (int m = 1; m < 8; m++) begin
      docmd(4'h7, 4'h8, 3'h0, 1'b1, prev[2] ? IN_B : T_B);
      docmd(4'h7, {1'b1, m[2:0]}, m[2:0], 1'b1, T_B);
      docmd(4'h3, 4'h8, m[2:0], 1'b0, 8'h00);
      prev = m[2:0];
    end
    docmd(4'h7, 4'h8, 3'h0, 1'b1, IN_B);
    $display("mode test done");
  endtask
  task automatic t_step();
    int n;
    n = 0;
    docmd(4'h7, 4'hD, 3'h5, 1'b1, T_B);
    @(posedge clk_sys);
    #1;
    cmdIn = '0;
    cmdValid = 1'b1;
    do begin
      @(posedge clk_sys);
      #1;
    end while (cmdTaken !== 1'b1 && cycles < 1900);
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (cmdTaken !== 1'b1 && n < 20);
    cmdValid = 1'b0;
    chk("stepCycles", STEP[7:0], n[7:0]);
    chk("ioMode", 8'h05, {5'h00, ioMode});
    $display("step test done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
    t_internal();
    t_modes();
    t_step();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [verif/periph_model.sv]
`timescale 1ns/1ps
`default_nettype none
module periph_model
  import byte_io_pkg::*;
#(
  parameter byte_t IN_BYTE = 8'hA5
) (
  input  wire logic    clk_sys,
  input  wire strobe_t ioStrobe,
  output var  byte_t   inBus
);
  // ----
  // Input bus gating
  // ----
  byte_t idleReg = 8'h00;
  always @(posedge clk_sys) begin
    idleReg <= idleReg + 8'h01;
  end
  always_comb begin
    inBus = (|ioStrobe[7:4]) ? IN_BYTE : ~idleReg;
  end
endmodule
`default_nettype wire

// [verilog/byte_io_cfg.svh]
// Functional notes
// - Mode register is exactly three bits
// - One idle, three output, four input modes
// - Space mode withdraws serial idle current
// - Mode loads only on opcode 7 command
// - c 8-F copies low c bits
// - Mode decoded onto bus control lines
// - c0 nop, c1 sense, c2 shift four
// - c4 supplies internal status as data
// - c7 enters console switches zero-seven
// - Each microstep takes 200 ns
// - c8 clears mode to idle
// - Mode MSB is the input indicator
// - Source is input bus or T
`ifndef BYTE_IO_CFG_SVH
`define BYTE_IO_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS   4000
`define STEP_TIME_NS    200
`define STEP_CYCLES     ((`STEP_TIME_NS * 1000) / `CLK_PERIOD_PS)

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define OPC_CONTROL     4'h7
`define C_NOP           4'h0
`define C_SENSE         4'h1
`define C_SHIFT4        4'h2
`define C_STATUS        4'h4
`define C_CONSOLE       4'h7
`define C_EXT_BIT       2
`define C_EXT_POS       3
`define SHIFT_AMOUNT    4

// ----------------------------------------------------------------
// Modes
// ----------------------------------------------------------------
`define MODE_IDLE       3'h0
`define MODE_SPACE      3'h3
`define MODE_INFLAG_POS 2
`define MODE_RESET      3'h0

`endif

// [verilog/byte_io_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "byte_io_cfg.svh"
module byte_io_ctrl
  import byte_io_pkg::*;
#(
  parameter int STEP_CYCLES = `STEP_CYCLES
) (
  input  wire logic    clk_sys,
  input  wire logic    rst,
  input  wire cmd_t    cmdIn,
  input  wire logic    cmdValid,
  input  wire byte_t   tRegIn,
  input  wire byte_t   fileIn,
  input  wire byte_t   inBusIn,
  input  wire byte_t   senseSwIn,
  input  wire byte_t   statusIn,
  input  wire byte_t   consoleSwIn,
  output var  logic    cmdTaken,
  output var  mode_t   ioMode,
  output var  strobe_t ioStrobe,
  output var  logic    spaceOut,
  output var  logic    inputFlag,
  output var  result_t result
);

  generate
    if (STEP_CYCLES < 2) begin : g_chk
      $error("byte_io_ctrl: STEP_CYCLES must be at least 2");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic strobe_t modeStrobes(input mode_t m);
    modeStrobes = strobe_t'(8'h01 << m);
  endfunction

  function automatic logic isControl(input cmd_t c);
    isControl = (c.opcode == `OPC_CONTROL);
  endfunction

  function automatic logic isExternal(input cmd_t c);
    isExternal = isControl(c) && c.cfield[`C_EXT_POS];
  endfunction

  // ----------------------------------------------------------------
  // Step sequencing
  // ----------------------------------------------------------------
  logic stepTick;

  step_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_step (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .stepTick (stepTick)
  );

  logic accept;
  assign accept = stepTick && cmdValid;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.taken = 1'b0;
    state_next.res.valid = 1'b0;
    if (accept) begin
      state_next.taken = 1'b1;
      if (isControl(cmdIn)) begin
        state_next.res.file = cmdIn.file;
        state_next.res.dest = cmdIn.dest;
        state_next.res.inhibit = cmdIn.inhibit;
        if (cmdIn.cfield[`C_EXT_POS]) begin
          state_next.mode = cmdIn.cfield[`C_EXT_BIT:0];
          state_next.res.valid = 1'b1;
          if (state_reg.inFlag) begin
            state_next.res.data = inBusIn;
          end else begin
            state_next.res.data = tRegIn;
          end
        end else begin
          case (cmdIn.cfield)
            `C_NOP: begin
              state_next.res.valid = 1'b0;
            end
            `C_SENSE: begin
              state_next.res.valid = 1'b1;
              state_next.res.data = senseSwIn;
            end
            `C_SHIFT4: begin
              state_next.res.valid = 1'b1;
              state_next.res.data = fileIn >> `SHIFT_AMOUNT;
            end
            `C_STATUS: begin
              state_next.res.valid = 1'b1;
              state_next.res.data = statusIn;
            end
            `C_CONSOLE: begin
              state_next.res.valid = 1'b1;
              state_next.res.data = consoleSwIn;
            end
            default: begin
              state_next.res.valid = 1'b0;
            end
          endcase
        end
      end
    end
    state_next.strobe = modeStrobes(state_next.mode);
    state_next.space = (state_next.mode == `MODE_SPACE);
    state_next.inFlag = state_next.mode[`MODE_INFLAG_POS];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.mode <= `MODE_RESET;
      state_reg.strobe <= modeStrobes(`MODE_RESET);
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmdTaken = state_reg.taken;
  assign ioMode = state_reg.mode;
  assign ioStrobe = state_reg.strobe;
  assign spaceOut = state_reg.space;
  assign inputFlag = state_reg.inFlag;
  assign result = state_reg.res;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] sinceTick;
  logic        seenTick;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sinceTick <= 16'h0000;
      seenTick <= 1'b0;
    end else if (stepTick) begin
      sinceTick <= 16'h0001;
      seenTick <= 1'b1;
    end else begin
      sinceTick <= sinceTick + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence ctlCmd(logic [3:0] cv);
    accept && isControl(cmdIn) && cmdIn.cfield == cv;
  endsequence

  sequence extCmd;
    accept && isExternal(cmdIn);
  endsequence

  step_rate_a: assert property (
    stepTick && seenTick |-> sinceTick == 16'(STEP_CYCLES))
    else $error("step spacing wrong");

  load_only_ctl_a: assert property (
    $changed(ioMode) |-> $past(accept) && $past(isControl(cmdIn)))
    else $error("mode changed without control command");

  ext_load_a: assert property (
    extCmd |=> ioMode == $past(cmdIn.cfield[2:0]) && cmdTaken)
    else $error("external mode not loaded");

  clear_mode_a: assert property (
    ctlCmd(4'h8) |=> ioMode == `MODE_IDLE && ioStrobe == 8'h01)
    else $error("clear mode failed");

  space_line_a: assert property (
    spaceOut == (ioMode == `MODE_SPACE))
    else $error("space output wrong");

  strobe_decode_a: assert property (
    $onehot(ioStrobe) && ioStrobe[ioMode])
    else $error("strobe decode wrong");

  input_src_a: assert property (
    extCmd |=> result.valid &&
      result.data == ($past(inputFlag) ? $past(inBusIn) : $past(tRegIn)))
    else $error("wrong source data");

  input_flag_a: assert property (
    inputFlag == ioMode[`MODE_INFLAG_POS])
    else $error("input flag wrong");

  sense_in_a: assert property (
    ctlCmd(4'h1) |=> result.valid && result.data == $past(senseSwIn))
    else $error("sense switches not entered");

  shift_four_a: assert property (
    ctlCmd(4'h2) |=> result.valid && result.data == ($past(fileIn) >> 4))
    else $error("shift right four wrong");

  nop_cmd_a: assert property (
    ctlCmd(4'h0) |=> !result.valid && $stable(ioMode))
    else $error("no operation had effect");

  int_status_a: assert property (
    ctlCmd(4'h4) |=> result.valid && result.data == $past(statusIn))
    else $error("internal status not entered");

  console_in_a: assert property (
    ctlCmd(4'h7) |=> result.valid && result.data == $past(consoleSwIn))
    else $error("console switches not entered");

  reset_idle_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    rst |=> ioMode == `MODE_IDLE && ioStrobe == 8'h01 && !spaceOut && !inputFlag &&
      !result.valid && !cmdTaken)
    else $error("reset did not idle the bus");

endmodule
`default_nettype wire

// [verilog/byte_io_pkg.sv]
package byte_io_pkg;

  typedef logic [2:0] mode_t;
  typedef logic [7:0] strobe_t;
  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] file;
    logic [3:0] cfield;
    logic       inhibit;
    logic [2:0] dest;
  } cmd_t;

  typedef struct packed {
    logic       valid;
    byte_t      data;
    logic [3:0] file;
    logic [2:0] dest;
    logic       inhibit;
  } result_t;

  typedef struct packed {
    mode_t   mode;
    strobe_t strobe;
    logic    space;
    logic    inFlag;
    logic    taken;
    result_t res;
  } ctrl_state_t;

  typedef struct packed {
    logic [7:0] count;
    logic       tick;
  } step_state_t;

endpackage

// [verilog/step_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "byte_io_cfg.svh"
module step_timer
  import byte_io_pkg::*;
#(
  parameter int STEP_CYCLES = `STEP_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  output var  logic stepTick
);

  generate
    if (STEP_CYCLES < 2 || STEP_CYCLES > 255) begin : g_chk
      $error("step_timer: STEP_CYCLES out of range");
    end
  endgenerate

  localparam logic [7:0] LAST = 8'(STEP_CYCLES - 1);

  step_state_t state_reg;
  step_state_t state_next;

  // ----------------------------------------------------------------
  // Step counter
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.count == LAST) begin
      state_next.count = 8'h00;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign stepTick = state_reg.tick;

endmodule
`default_nettype wire
